// ===== i2c_irq_pkg.sv
// Constants shared by the two-wire controller interrupt-clear and enable logic.
//
// Overview of operation
// - Reading the abort clear register clears the transmit-abort flag (bit 6) and the abort cause register.
// - Reading the abort clear register also releases the transmit FIFO from its flushed state.
// - The abort cause register is not cleared by that read while its bit 9 is set.
// - Reading the done clear register clears the slave-transmit-finished flag (bit 7).
// - Reading the activity clear register clears the activity flag only when the controller is idle.
// - The activity flag clears itself once the controller is disabled and the bus is quiet.
// - A read of the activity clear register returns the activity flag (bit 8).
// - Reading the start clear register clears the start-seen flag (bit 10).
// - Reading the broadcast clear register clears the broadcast-call flag (bit 11).
// - The enable bit turns the controller on at 1 and off at 0, holding both FIFOs erased.
// - After disabling, the masked status bits stay active until the controller is idle.
// - Disabled while transmitting, the controller finishes the transfer, then drops the TX buffer.
// - Disabled while receiving, the controller stops at the end of the byte without acknowledging.
// - Enabling or disabling takes effect two module clock cycles later.
package i2c_irq_pkg;

  // ****************************************************************
  // Register byte addresses.
  // ****************************************************************
  localparam logic [31:0] ADDR_ABORT_CLR    = 32'h5000_1554;
  localparam logic [31:0] ADDR_DONE_CLR     = 32'h5000_1558;
  localparam logic [31:0] ADDR_ACTIVITY_CLR = 32'h5000_155C;
  localparam logic [31:0] ADDR_STOP_CLR     = 32'h5000_1560;
  localparam logic [31:0] ADDR_START_CLR    = 32'h5000_1564;
  localparam logic [31:0] ADDR_BCAST_CLR    = 32'h5000_1568;
  localparam logic [31:0] ADDR_ON_CONTROL   = 32'h5000_156C;
  localparam logic [31:0] ADDR_STATE_FLAGS  = 32'h5000_1570;
  localparam logic [31:0] ADDR_ABORT_CAUSE  = 32'h5000_1580;
  localparam logic [31:0] ADDR_RAW_STATUS   = 32'h5000_15F0;
  localparam logic [31:0] ADDR_IRQ_MASK     = 32'h5000_15F4;
  localparam logic [31:0] ADDR_MASKED_STAT  = 32'h5000_15F8;

  // ****************************************************************
  // Field positions and widths.
  // ****************************************************************
  localparam int RAW_W         = 12;
  localparam int BIT_ABORT     = 6;
  localparam int BIT_DONE      = 7;
  localparam int BIT_ACTIVITY  = 8;
  localparam int BIT_STOP      = 9;
  localparam int BIT_START     = 10;
  localparam int BIT_BCAST     = 11;
  localparam int CAUSE_W       = 16;
  localparam int CAUSE_KEEP    = 9;
  localparam int FLAG_ACTIVITY = 0;
  localparam int FLAG_CTRL_ACT = 5;

  // ****************************************************************
  // Reset values and timing.
  // ****************************************************************
  localparam logic [RAW_W-1:0]   RAW_RESET   = 12'h000;
  localparam logic [RAW_W-1:0]   MASK_RESET  = 12'h000;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 16'h0000;
  localparam logic               ON_RESET    = 1'b0;
  localparam int                 ENABLE_DELAY = 2;

  // Controller run state.
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_DRAIN_TX,
    ST_DRAIN_RX
  } ctrl_state_t;

endpackage : i2c_irq_pkg

// ===== sync_two_flop.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module sync_two_flop #(
  parameter int W = 2
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // Refuse a width the flops cannot hold.
  if (W < 1) begin : g_bad_width
    $error("sync_two_flop width must be at least one");
  end

  // The first stage is read only by the second stage.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta   <= '1;
      o_sync <= '1;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : sync_two_flop
`default_nettype wire

// ===== enable_delay_line.sv
// Fixed pipeline that delays the software enable before the controller sees it.
`timescale 1ns/100ps
`default_nettype none
module enable_delay_line
  import i2c_irq_pkg::*;
#(
  parameter int DEPTH = ENABLE_DELAY
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_req,
  output var  logic o_eff
);

  logic [DEPTH-1:0] pipe;

  // The shift below needs at least two flops to index its low part.
  if (DEPTH < 2) begin : g_bad_depth
    $error("enable_delay_line depth must be at least two");
  end

  // Shift the request through DEPTH flops.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[DEPTH-2:0], i_req};
    end
  end

  assign o_eff = pipe[DEPTH-1];

endmodule : enable_delay_line
`default_nettype wire

// ===== i2c_irq_clear_and_enable.sv
// Interrupt clear registers, enable control and shutdown sequencing.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module i2c_irq_clear_and_enable
  import i2c_irq_pkg::*;
(
  input  wire logic               i_sys_clk,
  input  wire logic               i_sys_rst,
  // APB slave.
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [31:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output var  logic [31:0]        o_prdata,
  output var  logic               o_pready,
  output var  logic               o_pslverr,
  // Two-wire bus lines, observed only.
  input  wire logic               i_scl_pin,
  input  wire logic               i_sda_pin,
  // Transfer engine on the same clock.
  input  wire logic               i_abort_evt,
  input  wire logic [CAUSE_W-1:0] i_abort_cause,
  input  wire logic               i_done_evt,
  input  wire logic               i_bcast_evt,
  input  wire logic               i_xfer_busy,
  input  wire logic               i_xfer_rx,
  input  wire logic               i_xfer_done,
  input  wire logic               i_byte_end,
  // Controls back to the engine and FIFOs.
  output var  logic               o_ctrl_enabled,
  output var  logic               o_tx_flush,
  output var  logic               o_rx_flush,
  output var  logic               o_rx_ack_allow,
  output var  logic               o_stop_xfer,
  output var  logic               o_irq
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Narrow fields sit in the low bits, upper bits read as zero.
  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  // Next value of a sticky flag; a set in the clear cycle wins.
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [1:0]         pins_sync;
  logic               scl_s;
  logic               sda_s;
  logic               sda_prev;
  logic               bus_busy;
  logic               start_seen;
  logic               stop_seen;
  logic               ctrl_on;
  logic               en_eff;
  ctrl_state_t        state;
  ctrl_state_t        next_state;
  logic               ctrl_active;
  logic               activity_src;
  logic [RAW_W-1:0]   raw;
  logic [RAW_W-1:0]   next_raw;
  logic [RAW_W-1:0]   mask;
  logic [CAUSE_W-1:0] cause;
  logic               abort_flush_hold;
  logic               acc;
  logic               rd;
  logic               wr;
  logic               hit;
  logic [31:0]        rdata;
  logic               rd_abort;
  logic               rd_done;
  logic               rd_activity;
  logic               rd_stop;
  logic               rd_start;
  logic               rd_bcast;
  logic               rd_masked;

  // ****************************************************************
  // Bus line observation.
  // ****************************************************************

  // The lines come from pins, so they pass two flops first.
  sync_two_flop #(
    .W (2)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_scl_pin, i_sda_pin}),
    .o_sync    (pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // Start is SDA falling with SCL high, stop is SDA rising with SCL high.
  assign start_seen = scl_s & sda_prev & ~sda_s;
  assign stop_seen  = scl_s & ~sda_prev & sda_s;

  // Remember the previous synchronised data level.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_prev <= 1'b1;
    end else begin
      sda_prev <= sda_s;
    end
  end

  // The bus is busy from a start until the matching stop.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // APB access decode.
  // ****************************************************************

  // One wait state: effects and read data land on the edge that raises
  // pready, so the master completes on the following edge.
  assign acc = i_psel & i_penable & ~o_pready;
  assign rd  = acc & ~i_pwrite;
  assign wr  = acc & i_pwrite;

  // Clear actions fire on reads only; writes to them are dropped.
  assign rd_abort    = rd & (i_paddr == ADDR_ABORT_CLR);
  assign rd_done     = rd & (i_paddr == ADDR_DONE_CLR);
  assign rd_activity = rd & (i_paddr == ADDR_ACTIVITY_CLR);
  assign rd_stop     = rd & (i_paddr == ADDR_STOP_CLR);
  assign rd_start    = rd & (i_paddr == ADDR_START_CLR);
  assign rd_bcast    = rd & (i_paddr == ADDR_BCAST_CLR);
  assign rd_masked   = rd & (i_paddr == ADDR_MASKED_STAT);

  // Read mux and address hit; flags read back before they clear.
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    case (i_paddr)
      ADDR_ABORT_CLR:    rdata = zext16({15'h0000, raw[BIT_ABORT]});
      ADDR_DONE_CLR:     rdata = zext16({15'h0000, raw[BIT_DONE]});
      ADDR_ACTIVITY_CLR: rdata = zext16({15'h0000, raw[BIT_ACTIVITY]});
      ADDR_STOP_CLR:     rdata = zext16({15'h0000, raw[BIT_STOP]});
      ADDR_START_CLR:    rdata = zext16({15'h0000, raw[BIT_START]});
      ADDR_BCAST_CLR:    rdata = zext16({15'h0000, raw[BIT_BCAST]});
      ADDR_ON_CONTROL:   rdata = zext16({15'h0000, ctrl_on});
      ADDR_STATE_FLAGS: begin
        rdata[FLAG_ACTIVITY] = activity_src;
        rdata[FLAG_CTRL_ACT] = ctrl_active;
      end
      ADDR_ABORT_CAUSE:  rdata = zext16(cause);
      ADDR_RAW_STATUS:   rdata = zext16({4'h0, raw});
      ADDR_IRQ_MASK:     rdata = zext16({4'h0, mask});
      ADDR_MASKED_STAT:  rdata = zext16({4'h0, raw & mask});
      default:           hit   = 1'b0;
    endcase
  end

  // Bus answer; unmapped addresses complete with an error.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc & ~hit;
      if (rd) begin
        o_prdata <= rdata;
      end
    end
  end

  // ****************************************************************
  // Software control registers.
  // ****************************************************************

  // Enable bit; bit 0 only, the rest is ignored.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_on <= ON_RESET;
    end else if (wr && i_paddr == ADDR_ON_CONTROL) begin
      ctrl_on <= i_pwdata[0];
    end
  end

  // Interrupt mask, same layout as the raw status.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mask <= MASK_RESET;
    end else if (wr && i_paddr == ADDR_IRQ_MASK) begin
      mask <= i_pwdata[RAW_W-1:0];
    end
  end

  // The request reaches the controller two cycles later.
  enable_delay_line #(
    .DEPTH (ENABLE_DELAY)
  ) u_enable_delay (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_req     (ctrl_on),
    .o_eff     (en_eff)
  );

  // ****************************************************************
  // Run state and shutdown sequencing.
  // ****************************************************************

  // A disable during a transfer drains it instead of cutting it short.
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (en_eff) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (!en_eff) begin
          if (!i_xfer_busy) begin
            next_state = ST_OFF;
          end else if (i_xfer_rx) begin
            next_state = ST_DRAIN_RX;
          end else begin
            next_state = ST_DRAIN_TX;
          end
        end
      end
      ST_DRAIN_TX: begin
        if (i_xfer_done) begin
          next_state = ST_OFF;
        end
      end
      ST_DRAIN_RX: begin
        if (i_byte_end) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  // State register.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign ctrl_active  = (state != ST_OFF);
  assign activity_src = ctrl_active | bus_busy;

  // Engine controls follow the next state so they change with it.
  // A drain keeps the TX contents until the transfer ends, then drops
  // the remainder; a receive drain withholds the acknowledge.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ctrl_enabled <= 1'b0;
      o_rx_ack_allow <= 1'b0;
      o_stop_xfer    <= 1'b1;
      o_rx_flush     <= 1'b1;
    end else begin
      o_ctrl_enabled <= (next_state == ST_ON);
      o_rx_ack_allow <= (next_state == ST_ON);
      o_stop_xfer    <= (next_state == ST_OFF) ||
                        (next_state == ST_DRAIN_RX);
      o_rx_flush     <= (next_state == ST_OFF);
    end
  end

  // TX FIFO is held flushed while off and after an abort until released.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_flush <= 1'b1;
    end else begin
      o_tx_flush <= (next_state == ST_OFF) ||
                    sticky(abort_flush_hold, i_abort_evt, rd_abort);
    end
  end

  // ****************************************************************
  // Abort bookkeeping.
  // ****************************************************************

  // Flush hold set by an abort, released by the abort clear read.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      abort_flush_hold <= 1'b0;
    end else begin
      abort_flush_hold <= sticky(abort_flush_hold, i_abort_evt,
                                 rd_abort);
    end
  end

  // Cause bits accumulate; the clear read spares them while bit 9 is set.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cause <= CAUSE_RESET;
    end else if ((rd_abort || rd_masked) && !cause[CAUSE_KEEP]) begin
      cause <= i_abort_evt ? i_abort_cause : CAUSE_RESET;
    end else if (i_abort_evt) begin
      cause <= cause | i_abort_cause;
    end
  end

  // ****************************************************************
  // Raw interrupt flags.
  // ****************************************************************

  // Each flag is sticky; reading its clear register or the masked status
  // clears it, except that activity only drops once idle.
  always_comb begin
    next_raw = RAW_RESET;
    next_raw[BIT_ABORT] = sticky(raw[BIT_ABORT], i_abort_evt,
                                 rd_abort | rd_masked);
    next_raw[BIT_DONE]  = sticky(raw[BIT_DONE], i_done_evt,
                                 rd_done | rd_masked);
    next_raw[BIT_ACTIVITY] = sticky(raw[BIT_ACTIVITY], activity_src,
                                    ((rd_activity | rd_masked) &
                                     ~activity_src) |
                                    (~activity_src &
                                     (state == ST_OFF)));
    next_raw[BIT_STOP]  = sticky(raw[BIT_STOP], stop_seen,
                                 rd_stop | rd_masked);
    next_raw[BIT_START] = sticky(raw[BIT_START], start_seen,
                                 rd_start | rd_masked);
    next_raw[BIT_BCAST] = sticky(raw[BIT_BCAST], i_bcast_evt,
                                 rd_bcast | rd_masked);
  end

  // Disabling clears only the activity flag, once the bus is quiet, so masked status stays visible
  // until the controller idles.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      raw <= RAW_RESET;
    end else begin
      raw <= next_raw;
    end
  end

  // Level interrupt while any unmasked flag is set.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_raw & mask);
    end
  end

endmodule : i2c_irq_clear_and_enable
`default_nettype wire

// ===== i2c_irq_props.sv
// Port-level assertions for the interrupt-clear and enable block.
`timescale 1ns/100ps
`default_nettype none
module i2c_irq_props
  import i2c_irq_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        i_abort_evt,
  input wire logic        i_xfer_busy,
  input wire logic        i_xfer_rx,
  input wire logic        i_xfer_done,
  input wire logic        i_byte_end,
  input wire logic        o_ctrl_enabled,
  input wire logic        o_tx_flush,
  input wire logic        o_rx_flush,
  input wire logic        o_rx_ack_allow,
  input wire logic        o_stop_xfer
);
  // *****
  // Checks
  // *****
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // An access is taken one edge before its ready pulse.
  wire take   = i_psel && i_penable && !o_pready;
  wire rd_clr = take && !i_pwrite && i_paddr inside {ADDR_ABORT_CLR,
    ADDR_DONE_CLR, ADDR_ACTIVITY_CLR, ADDR_STOP_CLR, ADDR_START_CLR,
    ADDR_BCAST_CLR};
  wire wr_on  = take && i_pwrite && i_paddr == ADDR_ON_CONTROL;
  // The run state output changes on the third edge after the write.
  sequence s_late_off;
    o_ctrl_enabled [*3] ##1 !o_ctrl_enabled;
  endsequence
  sequence s_late_on;
    !o_ctrl_enabled [*3] ##1 o_ctrl_enabled;
  endsequence
  // A receive drain meets the end of its byte.
  sequence s_rx_end;
    !o_ctrl_enabled && !o_rx_flush && i_xfer_rx && i_byte_end;
  endsequence
  AST_CLR_READ_ZERO: assert property (
    rd_clr |=> o_pready && o_prdata[31:1] == 31'h0000_0000)
    else $error("clear read upper bits not zero");
  AST_OFF_DELAY: assert property (
    wr_on && !i_pwdata[0] && o_ctrl_enabled |=> s_late_off)
    else $error("disable not two cycles late");
  AST_ON_DELAY: assert property (
    wr_on && i_pwdata[0] && !o_ctrl_enabled && o_tx_flush && o_rx_flush
    |=> s_late_on)
    else $error("enable not two cycles late");
  AST_RUN_NO_ERASE: assert property (
    o_ctrl_enabled |-> !o_rx_flush && o_rx_ack_allow && !o_stop_xfer)
    else $error("running controller held stopped");
  AST_IDLE_OFF_ERASE: assert property (
    $fell(o_ctrl_enabled) && !i_xfer_busy
    |-> o_tx_flush && o_rx_flush && o_stop_xfer)
    else $error("idle disable did not erase");
  AST_RX_STOP: assert property (
    $fell(o_ctrl_enabled) && i_xfer_busy && i_xfer_rx
    |-> !o_rx_ack_allow && o_stop_xfer)
    else $error("receive not stopped without ack");
  AST_RX_FLUSH: assert property (s_rx_end |=> o_rx_flush)
    else $error("receive drain not ended at byte end");
  AST_TX_FINISH: assert property (
    !o_ctrl_enabled && !o_tx_flush && !i_xfer_rx && i_xfer_done
    |=> o_tx_flush && o_rx_flush)
    else $error("transmit buffer kept after transfer");
  AST_ABORT_FLUSH: assert property (i_abort_evt |=> o_tx_flush)
    else $error("abort did not hold transmit buffer");
endmodule : i2c_irq_props
bind i2c_irq_clear_and_enable i2c_irq_props u_props (.*);
`default_nettype wire

// ===== bus_peer.sv
// Far-side bus party that makes start and stop conditions.
`timescale 1ns/100ps
`default_nettype none
module bus_peer (
  input  wire logic i_sys_clk,
  input  wire logic i_start,
  input  wire logic i_stop,
  output var  logic o_scl,
  output var  logic o_sda
);
  // *****
  // Line model
  // *****
  // Both lines rest at the pull-up level; the clock stands still.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Start: data falls while the clock is high, then the clock drops.
  always @(posedge i_sys_clk) begin
    if (i_start) begin
      o_sda <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      o_scl <= 1'b0;
    end
  end
  // Stop: clock rises first, data last, so no false start is seen.
  always @(posedge i_sys_clk) begin
    if (i_stop) begin
      o_scl <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      o_sda <= 1'b1;
    end
  end
endmodule : bus_peer
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the interrupt-clear and enable block.
`timescale 1ns/100ps
`default_nettype none
module tb import i2c_irq_pkg::*;;
  // *****
  // Signals
  // *****
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE  = 32'h0000_0001;
  logic               i_sys_clk, i_sys_rst, i_psel, i_penable, i_pwrite;
  logic [31:0]        i_paddr, i_pwdata, o_prdata, q;
  logic               o_pready, o_pslverr, i_scl_pin, i_sda_pin, err;
  logic [CAUSE_W-1:0] i_abort_cause;
  logic               i_abort_evt, i_done_evt, i_bcast_evt, i_xfer_busy;
  logic               i_xfer_rx, i_xfer_done, i_byte_end, o_irq;
  logic               o_ctrl_enabled, o_tx_flush, o_rx_flush;
  logic               o_rx_ack_allow, o_stop_xfer, start_req, stop_req;
  int                 fails = 0, compares = 0, cyc = 0;
  logic [31:0]        rows [12] = '{ADDR_ABORT_CLR, ADDR_DONE_CLR,
    ADDR_ACTIVITY_CLR, ADDR_STOP_CLR, ADDR_START_CLR, ADDR_BCAST_CLR,
    ADDR_ON_CONTROL, ADDR_STATE_FLAGS, ADDR_ABORT_CAUSE, ADDR_RAW_STATUS,
    ADDR_IRQ_MASK, ADDR_MASKED_STAT};
  i2c_irq_clear_and_enable DUT (.*);
  bus_peer peer (.i_sys_clk, .i_start(start_req), .i_stop(stop_req),
    .o_scl(i_scl_pin), .o_sda(i_sda_pin));
  // Clock, and a watchdog well above the few hundred cycles needed.
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  // *****
  // Tasks
  // *****
  // Read data is taken at the edge that samples pready high.
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge i_sys_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) @(posedge i_sys_clk);
    q = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, ZERO);
  endtask : rd
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  // One-cycle pulse on the chosen engine or peer input.
  task automatic pulse(input int k);
    @(posedge i_sys_clk);
    case (k)
      0: i_done_evt <= 1'b1;
      1: i_bcast_evt <= 1'b1;
      2: start_req <= 1'b1;
      3: stop_req <= 1'b1;
      4: i_abort_evt <= 1'b1;
      5: i_xfer_done <= 1'b1;
      default: i_byte_end <= 1'b1;
    endcase
    @(posedge i_sys_clk);
    {i_done_evt, i_bcast_evt, start_req, stop_req} <= 4'h0;
    {i_abort_evt, i_xfer_done, i_byte_end} <= 3'h0;
    repeat (8) @(posedge i_sys_clk);
    #1;
  endtask : pulse
  // Only the bit under test is unmasked, so older flags stay silent.
  task automatic evt_clr(input int k, input logic [31:0] a, input int b);
    wr(ADDR_IRQ_MASK, ONE << b);
    pulse(k);
    chk(o_irq, ONE, "irq raised");
    wr(a, ONE);
    rd(ADDR_RAW_STATUS);
    chk(q[b], ONE, "flag kept on write");
    rd(a);
    chk(q, ONE, "clear read value");
    rd(ADDR_RAW_STATUS);
    chk(q[b], ZERO, "flag cleared");
    chk(o_irq, ZERO, "irq dropped");
    $display("end of test event %0d", k);
  endtask : evt_clr
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // *****
  // Sequence
  // *****
  initial begin
    {i_psel, i_penable, i_pwrite, i_abort_evt, i_done_evt} = 5'h00;
    {i_bcast_evt, i_xfer_busy, i_xfer_rx, i_xfer_done} = 4'h0;
    {i_byte_end, start_req, stop_req} = 3'h0;
    i_paddr = ZERO;
    i_pwdata = ZERO;
    i_abort_cause = 16'h0000;
    i_sys_rst = 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i]);
      chk(q, ZERO, "reset value");
    end
    rd(32'h5000_1500);
    chk(err, ONE, "unmapped");
    $display("end of test reset values");
    wr(ADDR_ON_CONTROL, ONE);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk({o_ctrl_enabled, o_tx_flush, o_rx_flush}, 3'h4, "on");
    evt_clr(0, ADDR_DONE_CLR, BIT_DONE);
    evt_clr(1, ADDR_BCAST_CLR, BIT_BCAST);
    evt_clr(2, ADDR_START_CLR, BIT_START);
    @(posedge i_sys_clk);
    i_abort_cause <= 16'h0003;
    pulse(4);
    chk(o_tx_flush, ONE, "abort flush");
    rd(ADDR_ABORT_CAUSE);
    chk(q, 32'h0000_0003, "cause");
    rd(ADDR_ABORT_CLR);
    chk(q, ONE, "abort read");
    rd(ADDR_ABORT_CAUSE);
    chk(q, ZERO, "cause cleared");
    chk(o_tx_flush, ZERO, "tx released");
    @(posedge i_sys_clk);
    i_abort_cause <= 16'h0200;
    pulse(4);
    rd(ADDR_ABORT_CLR);
    rd(ADDR_ABORT_CAUSE);
    chk(q, 32'h0000_0200, "cause kept");
    rd(ADDR_RAW_STATUS);
    chk(q[BIT_ABORT], ZERO, "abort flag");
    rd(ADDR_ACTIVITY_CLR);
    chk(q, ONE, "activity read");
    rd(ADDR_RAW_STATUS);
    chk(q[BIT_ACTIVITY], ONE, "activity kept");
    pulse(3);
    wr(ADDR_ON_CONTROL, ZERO);
    repeat (8) @(posedge i_sys_clk);
    rd(ADDR_RAW_STATUS);
    chk(q[BIT_ACTIVITY], ZERO, "activity self clear");
    wr(ADDR_IRQ_MASK, 32'h0000_0200);
    rd(ADDR_MASKED_STAT);
    chk(q, 32'h0000_0200, "masked stop kept while off");
    rd(ADDR_RAW_STATUS);
    chk(q[BIT_STOP], ZERO, "masked read clears");
    $display("end of test abort and activity");
    // Transmit drain, then receive drain, each from a running state.
    wr(ADDR_ON_CONTROL, ONE);
    i_xfer_busy <= 1'b1;
    wr(ADDR_ON_CONTROL, ZERO);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk({o_ctrl_enabled, o_tx_flush}, 2'h0, "tx drain");
    pulse(5);
    chk(o_tx_flush, ONE, "tx dropped");
    wr(ADDR_ON_CONTROL, ONE);
    i_xfer_rx <= 1'b1;
    wr(ADDR_ON_CONTROL, ZERO);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk({o_rx_ack_allow, o_stop_xfer, o_rx_flush}, 3'h2, "rx");
    pulse(6);
    chk(o_rx_flush, ONE, "rx dropped");
    wr(ADDR_ON_CONTROL, ONE);
    i_sys_rst <= 1'b1;
    {i_xfer_busy, i_xfer_rx} <= 2'h0;
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(ADDR_ON_CONTROL);
    chk(q, ZERO, "reset mid-run");
    $display("end of test drains");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
